// file: rtl/ipr_pkg.sv
/*
 * Constants for the interrupt priority register bank: register offsets,
 * implemented-bit masks, reset values and the map of priority fields.
 * Assumes a 32-bit APB slave that decodes a 12-bit byte address.
 */
package ipr_pkg;

   // ******************************************************************
   // widths and counts
   // ******************************************************************
   localparam int IPR_ADDR_W     = 12;
   localparam int IPR_DATA_W     = 32;
   localparam int IPR_REG_W      = 16;
   localparam int IPR_NUM_REGS   = 6;
   localparam int IPR_NUM_FIELDS = 18;
   localparam int IPR_FIELD_W    = 3;

   // ******************************************************************
   // register byte offsets
   // ******************************************************************
   localparam logic [IPR_ADDR_W-1:0] IPR_OFS_FIVE   = 12'h000;
   localparam logic [IPR_ADDR_W-1:0] IPR_OFS_SIX    = 12'h004;
   localparam logic [IPR_ADDR_W-1:0] IPR_OFS_SEVEN  = 12'h008;
   localparam logic [IPR_ADDR_W-1:0] IPR_OFS_EIGHT  = 12'h00c;
   localparam logic [IPR_ADDR_W-1:0] IPR_OFS_NINE   = 12'h010;
   localparam logic [IPR_ADDR_W-1:0] IPR_OFS_TWELVE = 12'h014;

   // ******************************************************************
   // register indices
   // ******************************************************************
   localparam logic [2:0] IPR_IDX_FIVE   = 3'h0;
   localparam logic [2:0] IPR_IDX_SIX    = 3'h1;
   localparam logic [2:0] IPR_IDX_SEVEN  = 3'h2;
   localparam logic [2:0] IPR_IDX_EIGHT  = 3'h3;
   localparam logic [2:0] IPR_IDX_NINE   = 3'h4;
   localparam logic [2:0] IPR_IDX_TWELVE = 3'h5;

   // ******************************************************************
   // implemented bits and reset values, index order five..twelve
   // ******************************************************************
   localparam logic [IPR_REG_W-1:0] IPR_IMPL_MASK [IPR_NUM_REGS] =
      '{16'h0007, 16'h7777, 16'h7777, 16'h7777, 16'h0777, 16'h0770};
   localparam logic [IPR_REG_W-1:0] IPR_RESET_VAL [IPR_NUM_REGS] =
      '{16'h0004, 16'h4444, 16'h4444, 16'h4444, 16'h0444, 16'h0440};

   // ******************************************************************
   // field codes
   // ******************************************************************
   localparam logic [IPR_FIELD_W-1:0] IPR_CODE_OFF  = 3'h0;
   localparam logic [IPR_FIELD_W-1:0] IPR_CODE_LOW  = 3'h1;
   localparam logic [IPR_FIELD_W-1:0] IPR_CODE_HIGH = 3'h7;

   // ******************************************************************
   // field map: register index and lsb of each source's field
   // ******************************************************************
   // 0 ext irq one | 1..4 timer four, out cmp four, out cmp three, dma two
   // 5..8 uart two tx, uart two rx, ext irq two, timer five
   // 9..12 can event, can rx ready, spi two event, spi two error
   // 13..15 in cap four, in cap three, dma three | 16..17 i2c two m, s
   localparam int IPR_FIELD_REG [IPR_NUM_FIELDS] =
      '{0, 1, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3, 4, 4, 4, 5, 5};
   localparam int IPR_FIELD_LSB [IPR_NUM_FIELDS] =
      '{0, 12, 8, 4, 0, 12, 8, 4, 0, 12, 8, 4, 0, 8, 4, 0, 8, 4};
   localparam int IPR_FLD_CAN_EVENT = 9;
   localparam int IPR_FLD_CAN_RX    = 10;

   // ******************************************************************
   // state of the register bank
   // ******************************************************************
   typedef struct packed {
      logic [IPR_NUM_REGS-1:0][IPR_REG_W-1:0] regs;
      logic [IPR_DATA_W-1:0]                  rdata;
      logic [1:0]                             canSync;
      logic                                   live;
   } ipr_state_t;

endpackage

// file: rtl/ipr_field_decode.sv
/*
 * Decodes one 3-bit priority field into a level and an enable.
 * Assumes the code comes from a register and the gate from the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module ipr_field_decode
   import ipr_pkg::*;
(
   // field code and source gate
   input  wire logic [IPR_FIELD_W-1:0] code,
   input  wire logic                   allow,
   // decoded priority
   output logic      [IPR_FIELD_W-1:0] level,
   output logic                        enable
);

   // ******************************************************************
   // decode
   // ******************************************************************
   always_comb begin
      level  = IPR_CODE_OFF;
      enable = 1'b0;
      if (allow && code != IPR_CODE_OFF) begin
         // codes map straight onto levels, low code one up to seven
         level  = code;
         enable = 1'b1;
      end
   end

endmodule

`default_nettype wire

// file: rtl/ipr_regs.sv
/*
 * Interrupt priority register bank, registers five to nine and twelve,
 * as an APB slave, with decoded priority level and enable per source.
 * Assumes an APB master on mclk; canPresent is a static pin level.
 */
// Design decisions made here: the register offsets and register access over APB.
// What this block does
// - code 111 gives priority level seven, the highest.
// - code 001 gives priority level one, lowest still able to interrupt.
// - code 000 disables the source; it is never presented.
// - implemented field bits read back the value last written.
// - unimplemented bits always read as zero.
// - every field resets to code 100, priority four.
// - register five holds only external irq one at bits 2-0.
// - register six: timer four, out compare four, three, dma two done.
// - register seven: uart two tx, uart two rx, ext irq two, timer five.
// - register eight: can event, can rx ready, spi two event, error.
// - register nine: in capture four, three, dma three done; 15-11 unused.
// - register twelve: i2c two master 10-8, slave 6-4; rest unused.
// - without a can module the can sources stay disabled.
`timescale 1ns/1ns
`default_nettype none

module ipr_regs
   import ipr_pkg::*;
(
   // clock and reset
   input  wire logic                                  mclk,
   input  wire logic                                  rst_n,
   // apb slave
   input  wire logic                                  psel,
   input  wire logic                                  penable,
   input  wire logic                                  pwrite,
   input  wire logic [IPR_ADDR_W-1:0]                 paddr,
   input  wire logic [IPR_DATA_W-1:0]                 pwdata,
   input  wire logic [3:0]                            pstrb,
   output logic      [IPR_DATA_W-1:0]                 prdata,
   output logic                                       pready,
   output logic                                       pslverr,
   // device variant strap
   input  wire logic                                  canPresent,
   // decoded priorities
   output logic      [IPR_NUM_FIELDS*IPR_FIELD_W-1:0] srcLevel,
   output logic      [IPR_NUM_FIELDS-1:0]             srcEnable
);

   // ******************************************************************
   // state
   // ******************************************************************
   ipr_state_t state_q;
   ipr_state_t state_d;

   logic                 hit;
   logic [2:0]           idx;
   logic                 setupRd;
   logic                 accessWr;
   logic                 accessAny;
   logic [IPR_REG_W-1:0] merged;

   // ******************************************************************
   // address decode
   // ******************************************************************
   always_comb begin
      hit = 1'b1;
      idx = IPR_IDX_FIVE;
      case (paddr)
         IPR_OFS_FIVE: begin
            idx = IPR_IDX_FIVE;
         end
         IPR_OFS_SIX: begin
            idx = IPR_IDX_SIX;
         end
         IPR_OFS_SEVEN: begin
            idx = IPR_IDX_SEVEN;
         end
         IPR_OFS_EIGHT: begin
            idx = IPR_IDX_EIGHT;
         end
         IPR_OFS_NINE: begin
            idx = IPR_IDX_NINE;
         end
         IPR_OFS_TWELVE: begin
            idx = IPR_IDX_TWELVE;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   assign setupRd   = psel && !penable && !pwrite;
   assign accessAny = psel && penable;
   assign accessWr  = accessAny && pwrite && hit;

   // zero wait states: read data is fetched in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = accessAny && !hit;
   assign prdata  = state_q.rdata;

   // ******************************************************************
   // next state
   // ******************************************************************
   always_comb begin
      state_d = state_q;
      merged  = state_q.regs[idx];
      state_d.live    = 1'b1;
      // variant strap is a pin: two flops before use
      state_d.canSync = {state_q.canSync[0], canPresent};
      if (pstrb[0]) begin
         merged[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
         merged[15:8] = pwdata[15:8];
      end
      if (accessWr) begin
         // mask keeps unused bits at zero whatever is written
         state_d.regs[idx] = merged & IPR_IMPL_MASK[idx];
      end
      if (setupRd) begin
         state_d.rdata = '0;
         if (hit) begin
            state_d.rdata[IPR_REG_W-1:0] =
               state_q.regs[idx] & IPR_IMPL_MASK[idx];
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int r = 0; r < IPR_NUM_REGS; r++) begin
            state_q.regs[r] <= IPR_RESET_VAL[r];
         end
         state_q.rdata   <= '0;
         // assume no can module until the strap is seen
         state_q.canSync <= 2'h0;
         state_q.live    <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   // ******************************************************************
   // per source decode
   // ******************************************************************
   for (genvar f = 0; f < IPR_NUM_FIELDS; f++) begin : gField
      localparam int REG = IPR_FIELD_REG[f];
      localparam int LSB = IPR_FIELD_LSB[f];
      localparam bit IS_CAN = (f == IPR_FLD_CAN_EVENT) || (f == IPR_FLD_CAN_RX);
      logic [IPR_FIELD_W-1:0] code;
      logic                   allow;

      // field placement per register table
      assign code  = state_q.regs[REG][LSB +: IPR_FIELD_W];
      assign allow = IS_CAN ? state_q.canSync[1] : 1'b1;

      ipr_field_decode uDec (
         .code   (code),
         .allow  (allow),
         .level  (srcLevel[f*IPR_FIELD_W +: IPR_FIELD_W]),
         .enable (srcEnable[f])
      );

      AST_CODE_SEVEN: assert property (@(posedge mclk) disable iff (!rst_n)
         (code == IPR_CODE_HIGH && allow) |->
            (srcEnable[f] && srcLevel[f*IPR_FIELD_W +: IPR_FIELD_W] == 3'h7))
         else $error("code seven not at level seven");

      AST_CODE_ONE: assert property (@(posedge mclk) disable iff (!rst_n)
         (code == IPR_CODE_LOW && allow) |->
            (srcEnable[f] && srcLevel[f*IPR_FIELD_W +: IPR_FIELD_W] == 3'h1))
         else $error("code one not at level one");

      AST_CODE_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
         (code == IPR_CODE_OFF) |->
            (!srcEnable[f] && srcLevel[f*IPR_FIELD_W +: IPR_FIELD_W] == 3'h0))
         else $error("disabled source still presented");

      AST_LINEAR: assert property (@(posedge mclk) disable iff (!rst_n)
         srcEnable[f] |-> (srcLevel[f*IPR_FIELD_W +: IPR_FIELD_W] == code))
         else $error("level does not follow code");

      AST_MID_CODES: assert property (@(posedge mclk) disable iff (!rst_n)
         (code inside {[3'h2:3'h6]} && allow) |->
            (srcEnable[f] && srcLevel[f*IPR_FIELD_W +: IPR_FIELD_W] == code))
         else $error("middle code not at its own level");

      AST_FIELD_MAP: assert property (@(posedge mclk) disable iff (!rst_n)
         (allow && $changed(state_q.regs[REG][LSB +: IPR_FIELD_W])) |->
            (srcLevel[f*IPR_FIELD_W +: IPR_FIELD_W] ==
             state_q.regs[REG][LSB +: IPR_FIELD_W]))
         else $error("field not taken from its register bits");

      if (IS_CAN) begin : gCan
         AST_CAN_GATED: assert property (@(posedge mclk) disable iff (!rst_n)
            (!state_q.canSync[1]) |-> !srcEnable[f])
            else $error("can source enabled without can module");
      end
   end

   // ******************************************************************
   // register checks
   // ******************************************************************
   sequence sWriteFull;
      (psel && !penable && pwrite && hit && pstrb[1:0] == 2'h3) ##1 (psel && penable);
   endsequence

   sequence sReadAccess;
      (psel && !penable && !pwrite && hit) ##1 (psel && penable && pready);
   endsequence

   AST_WRITE_STORES: assert property (@(posedge mclk) disable iff (!rst_n)
      sWriteFull |=> (state_q.regs[$past(idx)] ==
                      ($past(pwdata[IPR_REG_W-1:0]) & IPR_IMPL_MASK[$past(idx)])))
      else $error("written value not stored");

   AST_READ_UNUSED_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
      sReadAccess |-> (prdata[IPR_DATA_W-1:IPR_REG_W] == '0 &&
                      (prdata[IPR_REG_W-1:0] & ~IPR_IMPL_MASK[idx]) == '0))
      else $error("unused bits read nonzero");

   AST_READ_MATCHES: assert property (@(posedge mclk) disable iff (!rst_n)
      sReadAccess |-> (prdata[IPR_REG_W-1:0] == state_q.regs[idx]))
      else $error("read data differs from register");

   AST_BAD_ADDR: assert property (@(posedge mclk) disable iff (!rst_n)
      (psel && penable && !hit) |-> pslverr ##1 $stable(state_q.regs))
      else $error("unmapped access not refused");

   // ******************************************************************
   // bus protocol and lane checks
   // ******************************************************************
   // a lane left out of pstrb must come through a write untouched
   sequence sWriteLowOff;
      (psel && !penable && pwrite && hit && !pstrb[0]) ##1 (psel && penable);
   endsequence

   sequence sWriteHighOff;
      (psel && !penable && pwrite && hit && !pstrb[1]) ##1 (psel && penable);
   endsequence

   sequence sMissRead;
      (psel && !penable && !pwrite && !hit) ##1 (psel && penable && pready);
   endsequence

   AST_READY_NO_WAIT: assert property (@(posedge mclk) disable iff (!rst_n)
      (psel && penable) |-> pready)
      else $error("access phase stretched");

   AST_SLVERR_ACCESS_ONLY: assert property (@(posedge mclk) disable iff (!rst_n)
      !(psel && penable) |-> !pslverr)
      else $error("error flag outside access phase");

   AST_RDATA_UPPER_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
      prdata[IPR_DATA_W-1:IPR_REG_W] == '0)
      else $error("upper read data half nonzero");

   // read data is loaded only in a read setup cycle, so it cannot move under the master
   AST_RDATA_HOLDS: assert property (@(posedge mclk) disable iff (!rst_n)
      !(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data moved outside a read setup");

   AST_MISS_READ_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
      sMissRead |-> (prdata == '0))
      else $error("unmapped read returned data");

   AST_LOW_LANE_KEPT: assert property (@(posedge mclk) disable iff (!rst_n)
      sWriteLowOff |=> (state_q.regs[$past(idx)][7:0] ==
                        $past(state_q.regs[idx][7:0])))
      else $error("low byte written without its strobe");

   AST_HIGH_LANE_KEPT: assert property (@(posedge mclk) disable iff (!rst_n)
      sWriteHighOff |=> (state_q.regs[$past(idx)][15:8] ==
                         $past(state_q.regs[idx][15:8])))
      else $error("high byte written without its strobe");

   AST_READ_LEAVES_REGS: assert property (@(posedge mclk) disable iff (!rst_n)
      (psel && penable && !pwrite) |=> $stable(state_q.regs))
      else $error("read changed a register");

   for (genvar r = 0; r < IPR_NUM_REGS; r++) begin : gReg
      AST_UNUSED_HELD: assert property (@(posedge mclk) disable iff (!rst_n)
         (state_q.regs[r] & ~IPR_IMPL_MASK[r]) == '0)
         else $error("unused register bit set");

      AST_RESET_FOUR: assert property (@(posedge mclk) disable iff (!rst_n)
         (!state_q.live) |-> (state_q.regs[r] == IPR_RESET_VAL[r]))
         else $error("register not at reset value");
   end

   // ******************************************************************
   // strap synchroniser checks
   // ******************************************************************
   // the gate may open or close only two edges after the pin moved
   AST_STRAP_RISE: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(state_q.canSync[1]) |-> $past(canPresent, 2))
      else $error("can gate opened without the strap");

   // live masks the edge at which reset itself has just closed the gate
   AST_STRAP_FALL: assert property (@(posedge mclk) disable iff (!rst_n)
      ($fell(state_q.canSync[1]) && state_q.live) |-> !$past(canPresent, 2))
      else $error("can gate closed with the strap still high");

endmodule

`default_nettype wire

// file: tb/ipr_regs_tb.sv
/*
 * Self-checking bench for the priority register bank, driven over apb.
 * Assumes ipr_pkg and ipr_regs are compiled first; one clock, no partner.
 */
`timescale 1ns/1ns
`default_nettype none

module ipr_regs_tb
   import ipr_pkg::*;
;
   // ********************
   // signals and model
   // ********************
   logic                                  mclk;
   logic                                  rst_n;
   logic                                  psel;
   logic                                  penable;
   logic                                  pwrite;
   logic [IPR_ADDR_W-1:0]                 paddr;
   logic [IPR_DATA_W-1:0]                 pwdata;
   logic [3:0]                            pstrb;
   logic [IPR_DATA_W-1:0]                 prdata;
   logic                                  pready;
   logic                                  pslverr;
   logic                                  canPresent;
   logic [IPR_NUM_FIELDS*IPR_FIELD_W-1:0] srcLevel;
   logic [IPR_NUM_FIELDS-1:0]             srcEnable;
   logic [31:0]                           rd;
   logic                                  err;
   logic                                  canOn;
   logic [15:0]                           model [IPR_NUM_REGS];
   int                                    failures;
   int                                    tests_run;

   localparam logic [IPR_ADDR_W-1:0] OFS [IPR_NUM_REGS] = '{IPR_OFS_FIVE, IPR_OFS_SIX,
      IPR_OFS_SEVEN, IPR_OFS_EIGHT, IPR_OFS_NINE, IPR_OFS_TWELVE};
   // bit 3 of every nibble set so that dropped bits show up on read
   localparam logic [15:0] PAT [8] = '{16'h8888, 16'h9999, 16'haaaa, 16'hbbbb,
      16'hcccc, 16'hdddd, 16'heeee, 16'hffff};
   localparam logic [IPR_ADDR_W-1:0] UNMAP [3] = '{12'h018, 12'h002, 12'hffc};
   // rows start from every register holding its full mask
   typedef struct packed {
      logic [2:0]  idx;
      logic [31:0] wd;
      logic [3:0]  st;
      logic [31:0] exp;
   } ipr_row_t;
   localparam ipr_row_t ROWS [6] = '{
      '{3'h0, 32'hffff_fff8, 4'h3, 32'h0000_0000},
      '{3'h1, 32'h0000_0000, 4'h1, 32'h0000_7700},
      '{3'h2, 32'h0000_0000, 4'h2, 32'h0000_0077},
      '{3'h3, 32'h1234_5678, 4'h3, 32'h0000_5670},
      '{3'h4, 32'hffff_1234, 4'hc, 32'h0000_0777},
      '{3'h5, 32'h0000_3210, 4'h3, 32'h0000_0210}};

   ipr_regs dut (
      .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .canPresent(canPresent), .srcLevel(srcLevel),
      .srcEnable(srcEnable));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // ********************
   // compare and report
   // ********************
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_flag(input logic got, input logic exp);
      check_word({31'h0, got}, {31'h0, exp});
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ********************
   // apb master
   // ********************
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      input logic [3:0] st);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      pstrb <= st;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         failures++;
         tally_and_finish();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wreg(input int i, input logic [31:0] wd, input logic [3:0] st);
      logic [15:0] m;
      m = IPR_IMPL_MASK[i] & {{8{st[1]}}, {8{st[0]}}};
      apb(1'b1, OFS[i], wd, st);
      model[i] = (model[i] & ~m) | (wd[15:0] & m);
      check_flag(err, 1'b0);
   endtask

   task automatic rreg(input int i);
      apb(1'b0, OFS[i], 32'h0, 4'h0);
      check_word(rd, {16'h0000, model[i]});
      check_flag(err, 1'b0);
   endtask

   task automatic check_decode;
      logic [2:0] c;
      logic       en;
      @(negedge mclk);
      for (int f = 0; f < IPR_NUM_FIELDS; f++) begin
         c = model[IPR_FIELD_REG[f]][IPR_FIELD_LSB[f] +: 3];
         en = (c != 3'h0) && (canOn || (f != IPR_FLD_CAN_EVENT && f != IPR_FLD_CAN_RX));
         check_flag(srcEnable[f], en);
         check_word({29'h0, srcLevel[3*f +: 3]}, {29'h0, en ? c : 3'h0});
      end
   endtask

   // ********************
   // main sequence
   // ********************
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = '0;
      canPresent = 1'b1;
      canOn = 1'b0;
      failures = 0;
      tests_run = 0;
      for (int i = 0; i < IPR_NUM_REGS; i++) model[i] = IPR_RESET_VAL[i];
      repeat (7) @(posedge mclk);
      check_decode();
      @(posedge mclk);
      rst_n <= 1'b1;
      // can gate opens only after the two-flop strap synchroniser
      repeat (3) @(posedge mclk);
      canOn = 1'b1;
      for (int i = 0; i < IPR_NUM_REGS; i++) rreg(i);
      check_decode();
      $display("test reset done");
      for (int p = 0; p < 8; p++) begin
         for (int i = 0; i < IPR_NUM_REGS; i++) wreg(i, {16'hffff, PAT[p]}, 4'hf);
         check_decode();
         for (int i = 0; i < IPR_NUM_REGS; i++) rreg(i);
      end
      $display("test codes done");
      for (int r = 0; r < 6; r++) begin
         wreg(int'(ROWS[r].idx), ROWS[r].wd, ROWS[r].st);
         apb(1'b0, OFS[ROWS[r].idx], 32'h0, 4'h0);
         check_word(rd, ROWS[r].exp);
      end
      check_decode();
      $display("test rows done");
      for (int i = 0; i < IPR_NUM_REGS; i++) wreg(i, 32'h0, 4'h1);
      for (int i = 0; i < IPR_NUM_REGS; i++) rreg(i);
      $display("test strobes done");
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, UNMAP[k], 32'h0, 4'hf);
         check_flag(err, 1'b1);
         apb(1'b0, UNMAP[k], 32'h0, 4'h0);
         check_word(rd, 32'h0);
         check_flag(err, 1'b1);
      end
      for (int i = 0; i < IPR_NUM_REGS; i++) rreg(i);
      $display("test unmapped done");
      wreg(3, 32'h7777, 4'hf);
      canPresent <= 1'b0;
      repeat (3) @(posedge mclk);
      canOn = 1'b0;
      check_decode();
      rreg(3);
      canPresent <= 1'b1;
      repeat (3) @(posedge mclk);
      canOn = 1'b1;
      check_decode();
      $display("test can done");
      @(posedge mclk);
      rst_n <= 1'b0;
      canOn = 1'b0;
      for (int i = 0; i < IPR_NUM_REGS; i++) model[i] = IPR_RESET_VAL[i];
      check_decode();
      @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      canOn = 1'b1;
      for (int i = 0; i < IPR_NUM_REGS; i++) rreg(i);
      check_decode();
      $display("test midreset done");
      tally_and_finish();
   end
endmodule

`default_nettype wire
